//--- rtl/dss_drive_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module dss_drive_cfg (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic obj_wr,
	input wire logic obj_rd,
	input wire logic [15:0] obj_index,
	input wire logic [7:0] obj_sub,
	input wire logic [31:0] obj_wdata,
	output logic [31:0] obj_rdata,
	output logic obj_ack,
	output logic obj_err,
	input wire logic [7:0] op_mode,
	output logic closed_loop,
	output logic velocity_by_sramp,
	output logic auto_brake,
	output logic current_reduction,
	output logic torque_only,
	output logic speed_limiter,
	output logic brushless_motor_type,
	output logic [2:0] pos_fb_sel,
	output logic [2:0] speed_fb_sel,
	output logic [2:0] comm_fb_sel,
	output logic comm_fb_valid
);
	logic [31:0] drive_submode_select;
	dss_pkg::dss_mask_t fb_mask [1:dss_pkg::FB_MAX];
	logic hit_sub;
	logic hit_mask;
	logic hit_cnt;
	logic [2:0] mask_n;
	logic torque_mode;
	logic [31:0] next_rdata;

	dss_search_if pos_if ();
	dss_search_if spd_if ();
	dss_search_if com_if ();

	// Address decode of the two objects
	assign hit_sub = (obj_index == dss_pkg::IDX_SUBMODE)
		&& (obj_sub == dss_pkg::SUB_ZERO);
	assign hit_cnt = (obj_index == dss_pkg::IDX_FB_SEL)
		&& (obj_sub == dss_pkg::SUB_ZERO);
	assign hit_mask = (obj_index == dss_pkg::IDX_FB_SEL)
		&& (obj_sub >= dss_pkg::SUB_FB_FIRST)
		&& (obj_sub <= dss_pkg::FB_COUNT);
	assign mask_n = obj_sub[2:0];

	// Submode register
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			drive_submode_select <= dss_pkg::SUBMODE_RST;
		end
		else if (obj_wr && hit_sub)
		begin
			drive_submode_select <= obj_wdata;
		end
	end

	// Feedback masks; entry one is the sensorless feedback
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int n = 1; n <= dss_pkg::FB_MAX; n++)
			begin
				fb_mask[n] <= dss_pkg::MASK_RST;
			end
		end
		else if (obj_wr && hit_mask)
		begin
			fb_mask[mask_n] <= obj_wdata[7:0];
		end
	end

	// Read mux; count entry is fixed at the product figure
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (hit_sub)
		begin
			next_rdata = drive_submode_select;
		end
		else if (hit_cnt)
		begin
			next_rdata = {24'h00_0000, dss_pkg::FB_COUNT};
		end
		else if (hit_mask)
		begin
			next_rdata = {24'h00_0000, fb_mask[mask_n]};
		end
	end

	// One-cycle answer; count entry refuses writes
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			obj_rdata <= 32'h0000_0000;
			obj_ack <= 1'b0;
			obj_err <= 1'b0;
		end
		else
		begin
			obj_ack <= obj_wr || obj_rd;
			obj_err <= (obj_wr && !(hit_sub || hit_mask))
				|| (obj_rd && !(hit_sub || hit_mask || hit_cnt));
			if (obj_rd)
			begin
				obj_rdata <= next_rdata;
			end
		end
	end

	// Torque field only counts in the torque modes
	assign torque_mode = (op_mode == dss_pkg::OPM_PROFILE_TORQUE)
		|| (op_mode == dss_pkg::OPM_CSYNC_TORQUE);

	// Drive mode outputs, registered for clean control lines
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			closed_loop <= 1'b0;
			velocity_by_sramp <= 1'b0;
			auto_brake <= 1'b0;
			current_reduction <= 1'b0;
			brushless_motor_type <= 1'b0;
		end
		else
		begin
			closed_loop <= drive_submode_select[dss_pkg::SM_LOOP];
			velocity_by_sramp <= drive_submode_select[dss_pkg::SM_VSRAMP];
			auto_brake <= drive_submode_select[dss_pkg::SM_BRAKE];
			current_reduction <= drive_submode_select[dss_pkg::SM_REDUCE]
				&& !drive_submode_select[dss_pkg::SM_LOOP];
			brushless_motor_type <= drive_submode_select[dss_pkg::SM_MOTOR];
		end
	end

	// Torque structure; outside torque modes neither is asserted
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			torque_only <= 1'b0;
			speed_limiter <= 1'b0;
		end
		else
		begin
			torque_only <= torque_mode
				&& drive_submode_select[dss_pkg::SM_TORQUE];
			speed_limiter <= torque_mode
				&& !drive_submode_select[dss_pkg::SM_TORQUE];
		end
	end

	// Gather one mask bit per feedback for each controller
	always_comb
	begin
		for (int n = 1; n <= dss_pkg::FB_MAX; n++)
		begin
			pos_if.hit[n] = fb_mask[n][dss_pkg::MB_POS];
			spd_if.hit[n] = fb_mask[n][dss_pkg::MB_SPEED];
			com_if.hit[n] = fb_mask[n][dss_pkg::MB_COMM];
		end
	end

	dss_fb_search u_pos_search (
		.bus(pos_if)
	);

	dss_fb_search u_spd_search (
		.bus(spd_if)
	);

	dss_fb_search u_com_search (
		.bus(com_if)
	);

	// Position and speed picks stay live in open loop for the display
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pos_fb_sel <= dss_pkg::FB_SENSORLESS;
			speed_fb_sel <= dss_pkg::FB_SENSORLESS;
		end
		else
		begin
			pos_fb_sel <= pos_if.sel;
			speed_fb_sel <= spd_if.sel;
		end
	end

	// Commutation pick is held at sensorless in open loop
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			comm_fb_sel <= dss_pkg::FB_SENSORLESS;
			comm_fb_valid <= 1'b0;
		end
		else
		begin
			comm_fb_valid <= drive_submode_select[dss_pkg::SM_LOOP];
			if (drive_submode_select[dss_pkg::SM_LOOP])
			begin
				comm_fb_sel <= com_if.sel;
			end
			else
			begin
				comm_fb_sel <= dss_pkg::FB_SENSORLESS;
			end
		end
	end

	a_loop_follows: assert property (@(posedge clk)
		disable iff (sys_rst)
		closed_loop == $past(drive_submode_select[dss_pkg::SM_LOOP]))
		else $error("closed_loop does not follow loop field");

	a_sramp_follows: assert property (@(posedge clk)
		disable iff (sys_rst)
		(obj_wr && hit_sub) |-> ##2
		velocity_by_sramp == $past(obj_wdata[dss_pkg::SM_VSRAMP], 2))
		else $error("velocity simulation not taken from write");

	a_brake_follows: assert property (@(posedge clk)
		disable iff (sys_rst)
		(obj_wr && hit_sub) |-> ##2
		auto_brake == $past(obj_wdata[dss_pkg::SM_BRAKE], 2))
		else $error("brake control not taken from write");

	a_reduce_open: assert property (@(posedge clk)
		disable iff (sys_rst)
		current_reduction |-> !closed_loop)
		else $error("current reduction active in closed loop");

	a_torque_gate: assert property (@(posedge clk)
		disable iff (sys_rst)
		!$past(torque_mode) |-> !torque_only && !speed_limiter)
		else $error("torque structure active outside torque mode");

	a_torque_excl: assert property (@(posedge clk)
		disable iff (sys_rst)
		$past(torque_mode) |-> (torque_only != speed_limiter))
		else $error("torque structure not exclusive in torque mode");

	a_torque_field: assert property (@(posedge clk)
		disable iff (sys_rst)
		torque_only |-> $past(drive_submode_select[dss_pkg::SM_TORQUE]))
		else $error("torque controller alone without torque field");

	a_limiter_field: assert property (@(posedge clk)
		disable iff (sys_rst)
		speed_limiter |-> !$past(drive_submode_select[dss_pkg::SM_TORQUE]))
		else $error("speed limiter with torque field set");

	a_motor_follows: assert property (@(posedge clk)
		disable iff (sys_rst)
		(obj_wr && hit_sub) |-> ##2
		brushless_motor_type == $past(obj_wdata[dss_pkg::SM_MOTOR], 2))
		else $error("motor type not taken from write");

	// A write in the same cycle is refused, so the error follows it
	a_count_read: assert property (@(posedge clk)
		disable iff (sys_rst)
		(obj_rd && hit_cnt) |=> obj_ack && obj_err == $past(obj_wr)
		&& obj_rdata == {24'h00_0000, dss_pkg::FB_COUNT})
		else $error("feedback count read wrong");

	a_count_refuse: assert property (@(posedge clk)
		disable iff (sys_rst)
		(obj_wr && hit_cnt) |=> obj_ack && obj_err)
		else $error("write to feedback count not refused");

	a_pos_first: assert property (@(posedge clk)
		disable iff (sys_rst)
		$past(fb_mask[2][dss_pkg::MB_POS]) |-> pos_fb_sel == 3'h2)
		else $error("feedback 2 not first for position");

	a_speed_fallback: assert property (@(posedge clk)
		disable iff (sys_rst)
		($past(spd_if.hit[dss_pkg::FB_MAX:2]) == 3'h0)
		|-> speed_fb_sel == dss_pkg::FB_SENSORLESS)
		else $error("speed pick misses sensorless fallback");

	a_pos_fallback: assert property (@(posedge clk)
		disable iff (sys_rst)
		($past(pos_if.hit[dss_pkg::FB_MAX:2]) == 3'h0)
		|-> pos_fb_sel == dss_pkg::FB_SENSORLESS)
		else $error("position pick misses sensorless fallback");

	a_speed_skip: assert property (@(posedge clk)
		disable iff (sys_rst)
		($past(spd_if.hit[3:2]) == 2'h0 && $past(spd_if.hit[4]))
		|-> speed_fb_sel == 3'h4)
		else $error("speed search does not reach feedback 4");

	a_comm_open: assert property (@(posedge clk)
		disable iff (sys_rst)
		!closed_loop |-> comm_fb_sel == dss_pkg::FB_SENSORLESS
		&& !comm_fb_valid)
		else $error("commutation pick active in open loop");

	a_display_open: assert property (@(posedge clk)
		disable iff (sys_rst)
		(!closed_loop && $past(fb_mask[3][dss_pkg::MB_SPEED])
		&& !$past(fb_mask[2][dss_pkg::MB_SPEED]))
		|-> speed_fb_sel == 3'h3)
		else $error("display pick lost in open loop");

	a_mask_store: assert property (@(posedge clk)
		disable iff (sys_rst)
		(obj_wr && obj_index == dss_pkg::IDX_FB_SEL
		&& obj_sub == dss_pkg::SUB_FB_FIRST)
		|=> fb_mask[1] == $past(obj_wdata[7:0]))
		else $error("sensorless mask entry not stored");

	a_comm_bit: assert property (@(posedge clk)
		disable iff (sys_rst)
		(closed_loop && $past(fb_mask[2][dss_pkg::MB_COMM]))
		|-> comm_fb_sel == 3'h2)
		else $error("commutation bit ignored in closed loop");

	a_pos_bit: assert property (@(posedge clk)
		disable iff (sys_rst)
		($past(fb_mask[2][dss_pkg::MB_POS]) == 1'b0
		&& $past(fb_mask[3][dss_pkg::MB_POS]))
		|-> pos_fb_sel == 3'h3)
		else $error("position bit on feedback 3 ignored");

	a_speed_bit: assert property (@(posedge clk)
		disable iff (sys_rst)
		$past(fb_mask[2][dss_pkg::MB_SPEED]) |-> speed_fb_sel == 3'h2)
		else $error("speed bit on feedback 2 ignored");
endmodule : dss_drive_cfg
`default_nettype wire

//--- inc/dss_pkg.sv
`default_nettype none
package dss_pkg;
	// Object dictionary addressing
	localparam logic [15:0] IDX_SUBMODE = 16'h3202;
	localparam logic [15:0] IDX_FB_SEL = 16'h3203;
	localparam logic [7:0] SUB_ZERO = 8'h00;
	localparam logic [7:0] SUB_FB_FIRST = 8'h01;
	// Feedback table size
	localparam int FB_MAX = 4;
	localparam logic [7:0] FB_COUNT = 8'h04;
	localparam int FB_SEARCH_START = 2;
	localparam logic [2:0] FB_SENSORLESS = 3'h1;
	// Submode field positions
	localparam int SM_LOOP = 0;
	localparam int SM_VSRAMP = 1;
	localparam int SM_BRAKE = 2;
	localparam int SM_REDUCE = 3;
	localparam int SM_TORQUE = 4;
	localparam int SM_MOTOR = 5;
	// Feedback mask bit positions
	localparam int MB_POS = 0;
	localparam int MB_SPEED = 1;
	localparam int MB_COMM = 2;
	// Reset values
	localparam logic [31:0] SUBMODE_RST = 32'h0000_0000;
	localparam logic [7:0] MASK_RST = 8'h00;
	// Operating mode codes seen on the mode input
	localparam logic [7:0] OPM_PROFILE_TORQUE = 8'h04;
	localparam logic [7:0] OPM_CSYNC_TORQUE = 8'h0A;

	typedef logic [7:0] dss_mask_t;
endpackage : dss_pkg
`default_nettype wire

//--- inc/dss_search_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dss_search_if;
	logic [dss_pkg::FB_MAX:1] hit;
	logic [2:0] sel;
	modport req (output hit, input sel);
	modport srch (input hit, output sel);
endinterface : dss_search_if
`default_nettype wire

//--- rtl/dss_fb_search.sv
`timescale 1ns/1ps
`default_nettype none
module dss_fb_search (
	dss_search_if.srch bus
);
	logic [2:0] next_sel;

	// Walk downward so the lowest index from 2 up wins
	always_comb
	begin
		next_sel = dss_pkg::FB_SENSORLESS;
		for (int n = dss_pkg::FB_MAX; n >= dss_pkg::FB_SEARCH_START; n--)
		begin
			if (bus.hit[n])
			begin
				next_sel = 3'(n);
			end
		end
	end

	assign bus.sel = next_sel;
endmodule : dss_fb_search
`default_nettype wire

//--- verif/dss_obj_master.sv
`timescale 1ns/1ps
`default_nettype none
module dss_obj_master (
	input wire logic clk,
	output logic obj_wr,
	output logic obj_rd,
	output logic [15:0] obj_index,
	output logic [7:0] obj_sub,
	output logic [31:0] obj_wdata,
	input wire logic [31:0] obj_rdata,
	input wire logic obj_ack,
	input wire logic obj_err
);
	initial
	begin
		obj_wr = 1'b0;
		obj_rd = 1'b0;
		obj_index = 16'h0000;
		obj_sub = 8'h00;
		obj_wdata = 32'h0000_0000;
	end

	// One word per access, answer looked at exactly one cycle after
	// Idle fields inverted so a stale value can never pass for a fresh one
	task automatic access(input logic wr, input logic [15:0] idx,
		input logic [7:0] sub, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err, output logic ok);
		@(posedge clk);
		obj_wr <= wr;
		obj_rd <= ~wr;
		obj_index <= idx;
		obj_sub <= sub;
		obj_wdata <= wdata;
		@(posedge clk);
		obj_wr <= 1'b0;
		obj_rd <= 1'b0;
		obj_index <= ~idx;
		obj_sub <= ~sub;
		obj_wdata <= ~wdata;
		@(posedge clk);
		ok = (obj_ack === 1'b1);
		rdata = obj_rdata;
		err = obj_err;
	endtask : access
endmodule : dss_obj_master
`default_nettype wire

//--- verif/dss_drive_cfg_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dss_drive_cfg_tb_top;
	logic clk;
	logic sys_rst;
	logic [7:0] op_mode;
	logic obj_wr;
	logic obj_rd;
	logic [15:0] obj_index;
	logic [7:0] obj_sub;
	logic [31:0] obj_wdata;
	logic [31:0] obj_rdata;
	logic obj_ack;
	logic obj_err;
	logic [6:0] flags;
	logic [2:0] pos_fb_sel;
	logic [2:0] speed_fb_sel;
	logic [2:0] comm_fb_sel;
	logic comm_fb_valid;
	logic [31:0] rd;
	logic er;
	logic ok;
	int err_total;
	int tests_run;
	int cyc;
	logic [7:0] modes [3] = '{8'h04, 8'h0A, 8'h06};
	logic tq;

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	dss_obj_master i_mst (.clk(clk), .obj_wr(obj_wr), .obj_rd(obj_rd),
		.obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata),
		.obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err));

	dss_drive_cfg i_dut (.clk(clk), .sys_rst(sys_rst), .obj_wr(obj_wr),
		.obj_rd(obj_rd), .obj_index(obj_index), .obj_sub(obj_sub),
		.obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
		.obj_err(obj_err), .op_mode(op_mode), .closed_loop(flags[6]),
		.velocity_by_sramp(flags[5]), .auto_brake(flags[4]),
		.current_reduction(flags[3]), .torque_only(flags[2]),
		.speed_limiter(flags[1]), .brushless_motor_type(flags[0]),
		.pos_fb_sel(pos_fb_sel), .speed_fb_sel(speed_fb_sel),
		.comm_fb_sel(comm_fb_sel), .comm_fb_valid(comm_fb_valid));

	task automatic print_verdict();
		$display("Checks run %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Config outputs land one cycle after the ack
	task automatic wr(input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] data);
		i_mst.access(1'b1, idx, sub, data, rd, er, ok);
		chk("write ack", 32'h1, {31'h0, ok});
		#1;
	endtask : wr

	task automatic rd_chk(input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] exp, input logic exp_err);
		i_mst.access(1'b0, idx, sub, 32'h0000_0000, rd, er, ok);
		chk("read ack", 32'h1, {31'h0, ok});
		chk("read error", {31'h0, exp_err}, {31'h0, er});
		chk("read data", exp, rd);
	endtask : rd_chk

	task automatic chk_sel(input logic [2:0] p, input logic [2:0] s,
		input logic [2:0] c, input logic v);
		chk("feedback selects", {22'h0, p, s, c, v},
			{22'h0, pos_fb_sel, speed_fb_sel, comm_fb_sel, comm_fb_valid});
	endtask : chk_sel

	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 2000)
		begin
			err_total++;
			print_verdict();
		end
	end

	initial
	begin
		sys_rst = 1'b1;
		op_mode = 8'h00;
		err_total = 0;
		tests_run = 0;
		cyc = 0;
		repeat (20) @(posedge clk);
		#1;
		chk("reset flags", 32'h0, {25'h0, flags});
		chk_sel(3'h1, 3'h1, 3'h1, 1'b0);
		@(posedge clk);
		sys_rst <= 1'b0;
		rd_chk(16'h3202, 8'h00, 32'h0000_0000, 1'b0);
		rd_chk(16'h3203, 8'h00, 32'h0000_0004, 1'b0);
		for (int s = 1; s <= 4; s++)
			rd_chk(16'h3203, s[7:0], 32'h0000_0000, 1'b0);
		// Count entry is read-only: write refused, value kept
		i_mst.access(1'b1, 16'h3203, 8'h00, 32'h0000_0007, rd, er, ok);
		chk("count write error", 32'h1, {31'h0, er});
		rd_chk(16'h3203, 8'h00, 32'h0000_0004, 1'b0);
		rd_chk(16'h3204, 8'h00, 32'h0000_0000, 1'b1);
		rd_chk(16'h3203, 8'h05, 32'h0000_0000, 1'b1);
		for (int b = 0; b < 6; b++)
		begin
			wr(16'h3202, 8'h00, 32'h1 << b);
			chk("submode field", {25'h0, b == 0, b == 1, b == 2, b == 3,
				2'b00, b == 5}, {25'h0, flags});
			rd_chk(16'h3202, 8'h00, 32'h1 << b, 1'b0);
		end
		wr(16'h3202, 8'h00, 32'h0000_0009);
		chk("reduction closed", 32'h40, {25'h0, flags});
		for (int m = 0; m < 3; m++)
			for (int t = 0; t < 2; t++)
			begin
				wr(16'h3202, 8'h00, 32'(t) << 4);
				@(posedge clk);
				op_mode <= modes[m];
				@(posedge clk);
				#1;
				tq = (modes[m] == 8'h04) || (modes[m] == 8'h0A);
				chk("torque structure", {29'h0, tq && t == 1, tq && t == 0, 1'b0},
					{25'h0, flags});
			end
		wr(16'h3202, 8'h00, 32'h0000_0001);
		wr(16'h3203, 8'h01, 32'h0000_0007);
		chk_sel(3'h1, 3'h1, 3'h1, 1'b1);
		wr(16'h3203, 8'h02, 32'h0000_0001);
		wr(16'h3203, 8'h03, 32'h0000_0002);
		wr(16'h3203, 8'h04, 32'h0000_0007);
		chk_sel(3'h2, 3'h3, 3'h4, 1'b1);
		wr(16'h3203, 8'h02, 32'h0000_0007);
		chk_sel(3'h2, 3'h2, 3'h2, 1'b1);
		wr(16'h3203, 8'h02, 32'h0000_0000);
		wr(16'h3203, 8'h03, 32'hFFFF_FF00);
		chk_sel(3'h4, 3'h4, 3'h4, 1'b1);
		wr(16'h3202, 8'h00, 32'h0000_0000);
		chk_sel(3'h4, 3'h4, 3'h1, 1'b0);
		rd_chk(16'h3203, 8'h03, 32'h0000_0000, 1'b0);
		rd_chk(16'h3203, 8'h01, 32'h0000_0007, 1'b0);
		// Mid-run reset must clear the masks, not only the submode
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk_sel(3'h1, 3'h1, 3'h1, 1'b0);
		@(posedge clk);
		sys_rst <= 1'b0;
		rd_chk(16'h3203, 8'h04, 32'h0000_0000, 1'b0);
		wr(16'h3202, 8'h00, 32'h0000_0001);
		chk_sel(3'h1, 3'h1, 3'h1, 1'b1);
		print_verdict();
	end
endmodule : dss_drive_cfg_tb_top
`default_nettype wire
